// *** gpt_timer.sv ***
// Function
// (R1) Internal source counts one per instruction cycle up to the period value, then wraps to zero.
// (R2) In Idle the counter halts when the idle-stop bit (control bit 13) is set, else keeps counting.
// (R3) After Idle ends the counter resumes from its held value.
// (R4) Synchronous counter mode counts synchronised rising edges of the external pin.
// (R5) Asynchronous counter mode counts raw rising edges of the pin and wraps at the period.
// (R6) Asynchronous counter mode also halts in Idle when the idle-stop bit is one.
// (R7) An interrupt is requested on period match and on the gate falling edge.
// (R8) Software selects mode and options by writing the control register.
// (R9) With gate accumulate set, timer on and internal source, counting runs only while the gate is high.
// (R10) A two-bit prescale select divides the input by 1, 8, 64 or 256.
// (R11) The prescaler clears on count write, control write or reset; control writes keep the count. Here writes clear it only while it is running.
// (R12) In Sleep counting continues only when on, external source and asynchronous.
// (R13) Count and period are read/write words, and a match resets the count on the next counting edge.
//
// Our own choices: the address map and register access over AHB-Lite.
`include "gpt_params.svh"
`default_nettype none

module gpt_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Processor power state
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  // External clock or gate pin
  input  wire logic        external_clock_gate_pin,
  // Interrupt
  output logic             irq
);

  localparam logic [31:0] COUNT_ADDR  = `GPT_IDX2ADDR(`GPT_COUNT_IDX);
  localparam logic [31:0] PERIOD_ADDR = `GPT_IDX2ADDR(`GPT_PERIOD_IDX);
  localparam logic [31:0] CTRL_ADDR   = `GPT_IDX2ADDR(`GPT_CTRL_IDX);
  localparam logic [31:0] STATUS_ADDR = `GPT_IDX2ADDR(`GPT_STATUS_IDX);
  localparam logic [31:0] MASK_ADDR   = `GPT_IDX2ADDR(`GPT_MASK_IDX);

  localparam gpt_pkg::gpt_state_t RESET_STATE = '{
    count:         `GPT_COUNT_RST,
    period:        `GPT_PERIOD_RST,
    ctrl:          `GPT_CTRL_RST,
    status:        `GPT_STATUS_RST,
    mask:          `GPT_MASK_RST,
    pin_sync1:     1'b0,
    pin_sync2:     1'b0,
    pin_sync_prev: 1'b0,
    pin_raw_prev:  1'b0,
    dp_valid:      1'b0,
    dp_write:      1'b0,
    dp_addr:       32'h0000_0000,
    rdata:         32'h0000_0000
  };

  gpt_pkg::gpt_state_t state;
  gpt_pkg::gpt_state_t next_state;

  // Control fields
  logic timer_on_bit;
  logic idle_stop_bit;
  logic gate_accumulate_enable;
  logic clock_source_select;
  logic external_sync_select;
  gpt_pkg::gpt_ps_sel_t prescale_select;

  // Bus decode
  logic addr_phase;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // Counting
  logic sync_rise;
  logic raw_rise;
  logic gate_fall;
  logic src_tick;
  logic run_ok;
  logic ps_clear;
  logic count_tick;
  logic period_match;

  assign timer_on_bit           = state.ctrl[`GPT_CTRL_ON];
  assign idle_stop_bit          = state.ctrl[`GPT_CTRL_IDLE_STOP];
  assign gate_accumulate_enable = state.ctrl[`GPT_CTRL_GATE];
  assign clock_source_select    = state.ctrl[`GPT_CTRL_SRC];
  assign external_sync_select   = state.ctrl[`GPT_CTRL_SYNC];
  assign prescale_select        =
    gpt_pkg::gpt_ps_sel_t'(state.ctrl[`GPT_CTRL_PS_HI:`GPT_CTRL_PS_LO]);

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state.rdata;
  assign irq       = |(state.status & state.mask);

  // Only whole-word transfers are taken; others are ignored
  assign addr_phase = hsel && hready && (htrans == `GPT_HTRANS_NONSEQ)
                      && (hsize == `GPT_HSIZE_WORD);

  always_comb begin
    wr_count  = 1'b0;
    wr_period = 1'b0;
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    if (state.dp_valid && state.dp_write) begin
      if (state.dp_addr == COUNT_ADDR) begin
        wr_count = 1'b1;
      end else if (state.dp_addr == PERIOD_ADDR) begin
        wr_period = 1'b1;
      end else if (state.dp_addr == CTRL_ADDR) begin
        wr_ctrl = 1'b1;
      end else if (state.dp_addr == STATUS_ADDR) begin
        wr_status = 1'b1;
      end else if (state.dp_addr == MASK_ADDR) begin
        wr_mask = 1'b1;
      end
    end
  end

  // (R4) edge of synchronised pin
  assign sync_rise = state.pin_sync2 && !state.pin_sync_prev;
  // (R5) raw edge, no synchroniser latency
  assign raw_rise  = external_clock_gate_pin && !state.pin_raw_prev;
  assign gate_fall = !state.pin_sync2 && state.pin_sync_prev;

  always_comb begin
    src_tick = 1'b0;
    if (clock_source_select) begin
      // (R4) (R5) external sync or async
      src_tick = external_sync_select ? sync_rise : raw_rise;
    end else if (gate_accumulate_enable) begin
      // (R9) gate high accumulates
      src_tick = state.pin_sync2;
    end else begin
      // (R1) one per instruction cycle
      src_tick = 1'b1;
    end
  end

  always_comb begin
    run_ok = timer_on_bit;
    // (R2) (R6) idle stop; (R3) count is held
    if (cpu_idle && idle_stop_bit) begin
      run_ok = 1'b0;
    end
    // (R12) only async external runs in sleep
    if (cpu_sleep && !(clock_source_select && !external_sync_select)) begin
      run_ok = 1'b0;
    end
  end

  // (R11) prescaler clear on count or control write
  assign ps_clear = wr_count || wr_ctrl;

  // (R10) prescaler
  gpt_prescaler #(
    .CNT_W (8)
  ) u_prescaler (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (run_ok),
    .clear    (ps_clear),
    .sel      (prescale_select),
    .tick_in  (src_tick),
    .tick_out (count_tick)
  );

  assign period_match = count_tick && (state.count == state.period);

  // Sticky event flags, one per status bit
  logic [1:0] ev_hit;
  logic [1:0] status_next;

  // (R7) match event
  assign ev_hit[`GPT_EV_MATCH]     = period_match;
  // (R7) (R9) gate falling edge
  assign ev_hit[`GPT_EV_GATE_FALL] = gate_fall && timer_on_bit && gate_accumulate_enable
                                     && !clock_source_select;

  // Set wins over a same-cycle write-one clear, so no event is lost
  for (genvar i = 0; i < 2; i++) begin : g_flag
    assign status_next[i] = ev_hit[i] || (state.status[i] && !(wr_status && hwdata[i]));
  end

  always_comb begin
    next_state = state;

    // Pin sampling; first stage feeds only the second
    next_state.pin_sync1     = external_clock_gate_pin;
    next_state.pin_sync2     = state.pin_sync1;
    next_state.pin_sync_prev = state.pin_sync2;
    next_state.pin_raw_prev  = external_clock_gate_pin;

    // Counter update
    if (count_tick) begin
      if (period_match) begin
        // (R1) (R13) wrap on match
        next_state.count = 16'h0000;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end

    // Register writes; software write to count wins over counting
    if (wr_count) begin
      // (R13) count is writable
      next_state.count = hwdata[CNT_W-1:0];
    end
    if (wr_period) begin
      next_state.period = hwdata[CNT_W-1:0];
    end
    if (wr_ctrl) begin
      // (R8) (R11) mode select, count kept
      next_state.ctrl = hwdata[15:0] & `GPT_CTRL_WMASK;
    end
    if (wr_mask) begin
      next_state.mask = hwdata[1:0];
    end
    // (R7) event flags
    next_state.status = status_next;

    // Address phase capture
    next_state.dp_valid = addr_phase;
    next_state.dp_write = addr_phase && hwrite;
    if (addr_phase) begin
      next_state.dp_addr = haddr;
    end

    // Read data from next values so a prior write is seen
    next_state.rdata = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      if (haddr == COUNT_ADDR) begin
        next_state.rdata = {16'h0000, next_state.count};
      end else if (haddr == PERIOD_ADDR) begin
        next_state.rdata = {16'h0000, next_state.period};
      end else if (haddr == CTRL_ADDR) begin
        next_state.rdata = {16'h0000, next_state.ctrl};
      end else if (haddr == STATUS_ADDR) begin
        next_state.rdata = {30'h0000_0000, next_state.status};
      end else if (haddr == MASK_ADDR) begin
        next_state.rdata = {30'h0000_0000, next_state.mask};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// *** gpt_params.svh ***
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH

// Register indices; byte address is four times the index
`define GPT_COUNT_IDX      16'h0100
`define GPT_PERIOD_IDX     16'h0102
`define GPT_CTRL_IDX       16'h0104
`define GPT_STATUS_IDX     16'h0106
`define GPT_MASK_IDX       16'h0108
`define GPT_IDX2ADDR(idx)  ({14'h0000, (idx), 2'b00})

// Reset values
`define GPT_COUNT_RST      16'h0000
`define GPT_PERIOD_RST     16'hFFFF
`define GPT_CTRL_RST       16'h0000
`define GPT_STATUS_RST     2'h0
`define GPT_MASK_RST       2'h0

// Control field positions
`define GPT_CTRL_ON        15
`define GPT_CTRL_IDLE_STOP 13
`define GPT_CTRL_GATE      6
`define GPT_CTRL_PS_HI     5
`define GPT_CTRL_PS_LO     4
`define GPT_CTRL_SYNC      2
`define GPT_CTRL_SRC       1
`define GPT_CTRL_WMASK     16'hA076

// Status and mask bit positions
`define GPT_EV_MATCH       0
`define GPT_EV_GATE_FALL   1

// Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
`define GPT_PS_TC_1        8'h00
`define GPT_PS_TC_8        8'h07
`define GPT_PS_TC_64       8'h3F
`define GPT_PS_TC_256      8'hFF

// AHB-Lite codes
`define GPT_HTRANS_NONSEQ  2'b10
`define GPT_HSIZE_WORD     3'b010

`endif

// *** gpt_pkg.sv ***
`default_nettype none

package gpt_pkg;

  typedef enum logic [1:0] {
    GPT_PS_DIV1   = 2'h0,
    GPT_PS_DIV8   = 2'h1,
    GPT_PS_DIV64  = 2'h2,
    GPT_PS_DIV256 = 2'h3
  } gpt_ps_sel_t;

  typedef struct packed {
    logic [7:0] cnt;
  } gpt_ps_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic [15:0] ctrl;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        pin_sync_prev;
    logic        pin_raw_prev;
    logic        dp_valid;
    logic        dp_write;
    logic [31:0] dp_addr;
    logic [31:0] rdata;
  } gpt_state_t;

endpackage

`default_nettype wire

// *** gpt_prescaler.sv ***
`include "gpt_params.svh"
`default_nettype none

module gpt_prescaler #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Control
  input  wire logic               run,
  input  wire logic               clear,
  input  wire gpt_pkg::gpt_ps_sel_t sel,
  // Ticks
  input  wire logic               tick_in,
  output logic                    tick_out
);

  gpt_pkg::gpt_ps_state_t state;
  gpt_pkg::gpt_ps_state_t next_state;
  logic [CNT_W-1:0]       term;

  always_comb begin
    case (sel)
      gpt_pkg::GPT_PS_DIV1:  term = CNT_W'(`GPT_PS_TC_1);
      gpt_pkg::GPT_PS_DIV8:  term = CNT_W'(`GPT_PS_TC_8);
      gpt_pkg::GPT_PS_DIV64: term = CNT_W'(`GPT_PS_TC_64);
      default:               term = CNT_W'(`GPT_PS_TC_256);
    endcase
  end

  assign tick_out = run && tick_in && (state.cnt[CNT_W-1:0] == term);

  always_comb begin
    next_state = state;
    // Halted prescaler cannot be cleared
    if (run && clear) begin
      next_state.cnt = 8'h00;
    end else if (run && tick_in) begin
      if (tick_out) begin
        next_state.cnt = 8'h00;
      end else begin
        next_state.cnt = state.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// *** gpt_timer_props.sv ***
`include "gpt_params.svh"
`default_nettype none

module gpt_timer_props #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Power, pin, interrupt
  input wire logic        cpu_idle,
  input wire logic        cpu_sleep,
  input wire logic        external_clock_gate_pin,
  input wire logic        irq
);
  localparam logic [31:0] A_CTRL = `GPT_IDX2ADDR(`GPT_CTRL_IDX);
  localparam logic [31:0] A_PER  = `GPT_IDX2ADDR(`GPT_PERIOD_IDX);
  logic        rd_dp;
  logic        wr_dp;
  logic [31:0] dp_a;
  logic [15:0] ctrl_sh;
  logic [15:0] per_sh;
  wire logic   take = hsel && hready && htrans == `GPT_HTRANS_NONSEQ && hsize == `GPT_HSIZE_WORD;

  // Shadow of what software wrote, for readback checks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_dp   <= 1'b0;
      wr_dp   <= 1'b0;
      dp_a    <= 32'h00000000;
      ctrl_sh <= `GPT_CTRL_RST;
      per_sh  <= `GPT_PERIOD_RST;
    end else begin
      rd_dp <= take && !hwrite;
      wr_dp <= take && hwrite;
      if (take) dp_a <= haddr;
      if (wr_dp && dp_a == A_CTRL) ctrl_sh <= hwdata[15:0] & `GPT_CTRL_WMASK;
      if (wr_dp && dp_a == A_PER) per_sh <= hwdata[15:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_quiet_a: assert property (!rd_dp |-> hrdata == 32'h00000000)
    else $error("read data outside data phase");
  ctrl_readback_a: assert property (rd_dp && dp_a == A_CTRL |-> hrdata == {16'h0000, ctrl_sh})
    else $error("control readback wrong");
  period_readback_a: assert property (rd_dp && dp_a == A_PER |-> hrdata == {16'h0000, per_sh})
    else $error("period readback wrong");
  unmapped_zero_a: assert property (rd_dp && dp_a > 32'h00000420 |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  irq_reset_a: assert property ($past(sys_rst) |-> !irq)
    else $error("interrupt after reset");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_dp))
    else $error("interrupt cleared without write");
  irq_rise_a: assert property ($rose(irq) |-> $past(ctrl_sh[15]) || $past(wr_dp))
    else $error("interrupt while timer off");

  cover property (rd_dp && dp_a == A_CTRL);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule

bind gpt_timer gpt_timer_props #(.CNT_W(CNT_W)) chk (.core_clk, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cpu_idle,
  .cpu_sleep, .external_clock_gate_pin, .irq);

`default_nettype wire

// *** gpt_pin_src.sv ***
`default_nettype none

module gpt_pin_src (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Pulse shape
  input  wire logic       en,
  input  wire logic [7:0] hi_len,
  // Pin
  output logic            pin
);
  logic [7:0] n;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin <= 1'b0;
      n   <= 8'h00;
    end else if (!en) begin
      pin <= 1'b0;
      n   <= 8'h00;
    end else if (n == (pin ? hi_len : 8'h03) - 8'h01) begin
      pin <= ~pin;
      n   <= 8'h00;
    end else begin
      n <= n + 8'h01;
    end
  end
endmodule

`default_nettype wire

// *** gp_16bit_interval_timer_test.sv ***
`include "gpt_params.svh"
`default_nettype none

module gp_16bit_interval_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, pen = 0, prev = 0;
  logic        cpu_idle = 0, cpu_sleep = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, lfsr = 32'h0001354E;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic [7:0]  hl = 8'h05;
  logic [15:0] xc[6] = '{16'h8002, 16'h8006, 16'hA002, 16'h8002, 16'h8006, 16'h8000};
  logic [15:0] ri[6] = '{16'h0100, 16'h0102, 16'h0104, 16'h0106, 16'h0108, 16'h0200};
  int          ro[6] = '{0, 65535, 0, 0, 0, 0};
  int          mismatches = 0, n_compared = 0, cyc = 0, rises = 0, highs = 0, e, p, w;
  wire logic   hreadyout, hresp, irq, pin;
  wire logic [31:0] hrdata;

  always #5 core_clk = ~core_clk;

  gpt_pin_src src (.core_clk, .sys_rst, .en(pen), .hi_len(hl), .pin);
  gpt_timer uut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_idle, .cpu_sleep,
    .external_clock_gate_pin(pin), .irq);

  // Reference edge and level counts, plus the hang limit
  always @(posedge core_clk) begin
    cyc++;
    rises += int'(pin && !prev);
    highs += int'(pin);
    prev = pin;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string n);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic bus(input logic wt, input logic [15:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= `GPT_IDX2ADDR(idx);
    htrans <= `GPT_HTRANS_NONSEQ;
    hwrite <= wt;
    hsize  <= `GPT_HSIZE_WORD;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [15:0] idx, input int x, input string n);
    bus(1'b0, idx, 32'h0);
    chk(rd, x, n);
  endtask

  // Counting spans the two control writes: ticks are wait plus three
  task automatic run(input logic [15:0] c, input int wt);
    bus(1'b1, `GPT_CTRL_IDX, c);
    repeat (wt) @(posedge core_clk);
    bus(1'b1, `GPT_CTRL_IDX, 32'h0);
  endtask

  function automatic int nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr[15:0]);
  endfunction

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdc(ri[i], ro[i], "reset value");
    $display("reset test done");
    bus(1'b1, `GPT_MASK_IDX, 32'h1);
    for (int k = 0; k < 3; k++) begin
      p = 3 + nxt() % 8;
      w = 20 + nxt() % 30;
      bus(1'b1, `GPT_PERIOD_IDX, p);
      bus(1'b1, `GPT_COUNT_IDX, 32'h0);
      run(16'h8000, w);
      rdc(`GPT_COUNT_IDX, (w + 3) % (p + 1), "wrapped count");
      rdc(`GPT_STATUS_IDX, int'(w + 3 > p), "match flag");
      chk(irq, w + 3 > p, "irq");
      bus(1'b1, `GPT_STATUS_IDX, 32'h3);
      #1 chk(irq, 1'b0, "irq cleared");
    end
    $display("period test done");
    bus(1'b1, `GPT_PERIOD_IDX, 32'hFFFF);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `GPT_COUNT_IDX, 32'h0);
      run(16'h8000 | (16'(s) << 4), 600);
      rdc(`GPT_COUNT_IDX, 603 >> (s == 3 ? 8 : 3 * s), "prescaled count");
    end
    $display("prescale test done");
    bus(1'b1, `GPT_COUNT_IDX, 32'h0);
    e = 0;
    for (int i = 0; i < 4; i++) begin
      cpu_idle <= i[0];
      run(i == 3 ? 16'h8000 : 16'hA000, 30);
      e += (i == 1) ? 0 : 33;
      rdc(`GPT_COUNT_IDX, e, "idle count");
    end
    $display("idle test done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `GPT_COUNT_IDX, 32'h0);
      cpu_idle  <= (i == 2);
      cpu_sleep <= (i >= 3);
      bus(1'b1, `GPT_CTRL_IDX, xc[i]);
      rises = 0;
      pen <= 1'b1;
      repeat (60) @(posedge core_clk);
      pen <= 1'b0;
      repeat (12) @(posedge core_clk);
      bus(1'b1, `GPT_CTRL_IDX, 32'h0);
      cpu_idle  <= 1'b0;
      cpu_sleep <= 1'b0;
      e = (i == 2 || i >= 4) ? 0 : rises;
      rdc(`GPT_COUNT_IDX, e, "pin count");
    end
    $display("counter test done");
    hl <= 8'h02;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `GPT_MASK_IDX, 32'h2 * (1 - k));
      bus(1'b1, `GPT_COUNT_IDX, 32'h0);
      bus(1'b1, `GPT_CTRL_IDX, 32'h8040);
      highs = 0;
      pen <= 1'b1;
      repeat (40) @(posedge core_clk);
      pen <= 1'b0;
      repeat (12) @(posedge core_clk);
      bus(1'b1, `GPT_CTRL_IDX, 32'h0);
      rdc(`GPT_COUNT_IDX, highs, "gated count");
      rdc(`GPT_STATUS_IDX, 2, "gate flag");
      chk(irq, k == 0, "gate irq");
      bus(1'b1, `GPT_STATUS_IDX, 32'h2);
    end
    $display("gate test done");
    report_and_stop();
  end
endmodule

`default_nettype wire
